// ===== logic/dpsba_pkg.sv
// Functional notes
// - packed discard drops low-count bytes, no writes
// - discards tracked per byte lane
// - planar discard drops first-word count from luma
// - second word counts drop from both chroma queues
// - branch loads program counter from second word
// - branch unconditional; software gives word-aligned target
// - align waits until queue tag equals status
// - bit 15 masks field sequence errors
// - line first/last flags mark line edges
// - before alignment queue data is dropped
// - illegal opcode or code raises interrupt, halts
// - discards ignore the queue fill trigger point
package dpsba_pkg;
  // ****************************************************
  // instruction encoding
  // ****************************************************
  localparam logic [3:0] OP_DISCARD  = 4'h2;
  localparam logic [3:0] OP_PLANAR   = 4'hA;
  localparam logic [3:0] OP_BRANCH   = 4'h7;
  localparam logic [3:0] OP_ALIGN    = 4'h8;
  localparam int         OPC_LSB     = 28;
  localparam int         FIRST_BIT   = 27;
  localparam int         LAST_BIT    = 26;
  localparam int         IRQ_BIT     = 24;
  localparam int         CLR_LSB     = 20;
  localparam int         SET_LSB     = 16;
  localparam int         AMASK_BIT   = 15;
  localparam int         CNT_W       = 12;
  localparam int         CNT2_LSB    = 16;
  localparam int         CODE_W      = 4;
  localparam int         NFLAG       = 4;
  // status codes accepted by the align instruction; code 0 is reserved
  localparam logic [15:0] ALIGN_CODE_OK = 16'hFFFE;
  // ****************************************************
  // register map and fields
  // ****************************************************
  localparam int         AW          = 4;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_START   = 4'h1;
  localparam logic [3:0] REG_PC      = 4'h2;
  localparam logic [3:0] REG_STAT    = 4'h3;
  localparam logic [3:0] REG_MASK    = 4'h4;
  localparam logic [3:0] REG_FLAGS   = 4'h5;
  localparam int         NEVT        = 3;
  localparam int         EV_DONE     = 0;
  localparam int         EV_ILLEGAL  = 1;
  localparam int         EV_FSEQ     = 2;
  localparam logic [31:0] START_RST  = 32'h0000_0000;
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
  // ****************************************************
  // sequencer states
  // ****************************************************
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH0 = 3'b001,
    S_FETCH1 = 3'b010,
    S_DISC  = 3'b011,
    S_ALIGN = 3'b100,
    S_HALT  = 3'b101
  } dpsba_state_t;
endpackage

// ===== logic/dpsba_core.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module dpsba_core
  import dpsba_pkg::*;
(
  // clock, reset, enable
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  // register port
  input  wire logic [AW-1:0]     reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // instruction fetch
  output logic                   fetch_req_o,
  output logic      [31:0]       fetch_addr_o,
  input  wire logic              fetch_ack_i,
  input  wire logic [31:0]       fetch_data_i,
  // queue read ports: 0 luma/packed, 1 first chroma, 2 second chroma
  input  wire logic [2:0]        q_valid_i,
  output logic      [2:0]        q_pop_o,
  input  wire logic [CODE_W-1:0] q_tag_i,
  input  wire logic              fseq_err_i,
  // line markers and interrupt
  output logic                   line_first_o,
  output logic                   line_last_o,
  output logic                   irq_o
);
  // ****************************************************
  // state
  // ****************************************************
  dpsba_state_t          state_reg;
  logic [31:0]           pc_reg;
  logic [31:0]           start_reg;
  logic [31:0]           w0_reg;
  logic [CNT_W-1:0]      cnt_reg [3];
  logic [1:0]            lane_reg [3];
  logic [1:0]            sel_reg;
  logic [NEVT-1:0]       stat_reg;
  logic [NEVT-1:0]       mask_reg;
  logic [NFLAG-1:0]      flags_reg;
  logic                  run_reg;
  logic                  acc;
  logic                  fire;
  logic                  retire;
  logic                  illegal;
  logic                  sel_done;
  logic                  tag_hit;
  logic [3:0]            op0;
  logic [NEVT-1:0]       ev_set;

  function automatic logic is_legal(input logic [31:0] w);
    logic [3:0] op;
    op = w[31:OPC_LSB];
    is_legal = (op == OP_DISCARD) || (op == OP_PLANAR) ||
               (op == OP_BRANCH) ||
               ((op == OP_ALIGN) && ALIGN_CODE_OK[w[CODE_W-1:0]]);
  endfunction

  assign acc      = ce_i && fetch_ack_i && fetch_req_o;
  assign op0      = fetch_data_i[31:OPC_LSB];
  assign illegal  = acc && (state_reg == S_FETCH0) &&
                    !is_legal(fetch_data_i);
  assign tag_hit  = q_tag_i == w0_reg[CODE_W-1:0];
  assign sel_done = cnt_reg[sel_reg] == '0;
  assign fire     = ce_i && (state_reg == S_DISC) && !sel_done &&
                    q_valid_i[sel_reg];

  // ****************************************************
  // instruction completion
  // ****************************************************
  always_comb begin
    retire = 1'b0;
    if (ce_i) begin
      unique case (state_reg)
        S_FETCH1: retire = acc && (w0_reg[31:OPC_LSB] == OP_BRANCH);
        S_DISC:   retire = sel_done && (sel_reg == 2'd2);
        S_ALIGN:  retire = q_valid_i[0] && tag_hit;
        S_IDLE, S_FETCH0, S_HALT: retire = 1'b0;
        default:  retire = 1'b0;
      endcase
    end
  end

  // ****************************************************
  // fetch port
  // ****************************************************
  assign fetch_req_o  = run_reg &&
                        (state_reg == S_FETCH0 || state_reg == S_FETCH1);
  assign fetch_addr_o = pc_reg;

  // ****************************************************
  // queue pops
  // ****************************************************
  always_comb begin
    q_pop_o = 3'b000;
    if (fire && (lane_reg[sel_reg] == 2'd3 || cnt_reg[sel_reg] == 12'h001 &&
        lane_reg[sel_reg] == 2'd3))
      q_pop_o[sel_reg] = 1'b1;
    if (ce_i && state_reg == S_ALIGN && q_valid_i[0] && !tag_hit)
      q_pop_o[0] = 1'b1;
  end

  // ****************************************************
  // sequencer
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= S_IDLE;
      run_reg   <= 1'b0;
      pc_reg    <= START_RST;
      w0_reg    <= 32'h0000_0000;
      sel_reg   <= 2'd0;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        run_reg   <= reg_wdata_i[0];
        pc_reg    <= start_reg;
        state_reg <= reg_wdata_i[0] ? S_FETCH0 : S_IDLE;
      end else begin
        unique case (state_reg)
          S_IDLE, S_HALT: state_reg <= state_reg;
          S_FETCH0: if (acc) begin
            w0_reg  <= fetch_data_i;
            pc_reg  <= pc_reg + WORD_STEP;
            sel_reg <= 2'd0;
            if (illegal) begin
              state_reg <= S_HALT;
              run_reg   <= 1'b0;
            end else if (op0 == OP_DISCARD)
              state_reg <= S_DISC;
            else
              state_reg <= S_FETCH1;
          end
          S_FETCH1: if (acc) begin
            unique case (w0_reg[31:OPC_LSB])
              OP_BRANCH: begin
                pc_reg    <= fetch_data_i;
                state_reg <= S_FETCH0;
              end
              OP_PLANAR: begin
                pc_reg    <= pc_reg + WORD_STEP;
                state_reg <= S_DISC;
              end
              default: begin
                pc_reg    <= pc_reg + WORD_STEP;
                state_reg <= S_ALIGN;
              end
            endcase
          end
          S_DISC: if (sel_done) begin
            if (sel_reg == 2'd2) state_reg <= S_FETCH0;
            else sel_reg <= sel_reg + 2'd1;
          end
          S_ALIGN: if (retire) state_reg <= S_FETCH0;
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************************
  // byte counters and lanes
  // ****************************************************
  for (genvar q = 0; q < 3; q++) begin : g_q
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        cnt_reg[q]  <= '0;
        lane_reg[q] <= 2'd0;
      end else if (ce_i) begin
        if (acc && state_reg == S_FETCH0 && q == 0 && op0 == OP_DISCARD)
          cnt_reg[q] <= fetch_data_i[CNT_W-1:0];
        else if (acc && state_reg == S_FETCH0 && q == 0 && op0 == OP_PLANAR)
          cnt_reg[q] <= fetch_data_i[CNT_W-1:0];
        else if (acc && state_reg == S_FETCH1 && q == 1 &&
                 w0_reg[31:OPC_LSB] == OP_PLANAR)
          cnt_reg[q] <= fetch_data_i[CNT_W-1:0];
        else if (acc && state_reg == S_FETCH1 && q == 2 &&
                 w0_reg[31:OPC_LSB] == OP_PLANAR)
          cnt_reg[q] <= fetch_data_i[CNT2_LSB+CNT_W-1:CNT2_LSB];
        else if (fire && sel_reg == 2'(q)) begin
          cnt_reg[q]  <= cnt_reg[q] - 12'h001;
          lane_reg[q] <= lane_reg[q] + 2'd1;
        end
        if (q == 0 && q_pop_o[0] && state_reg == S_ALIGN)
          lane_reg[q] <= 2'd0;
      end
    end
  end

  // ****************************************************
  // line markers
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      line_first_o <= 1'b0;
      line_last_o  <= 1'b0;
    end else if (ce_i) begin
      line_first_o <= acc && state_reg == S_FETCH0 && !illegal &&
                      (op0 == OP_DISCARD || op0 == OP_PLANAR) &&
                      fetch_data_i[FIRST_BIT];
      line_last_o  <= retire && state_reg == S_DISC &&
                      w0_reg[LAST_BIT];
    end
  end

  // ****************************************************
  // program flags and interrupt status
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      flags_reg <= '0;
    else if (ce_i && retire)
      flags_reg <= (flags_reg & ~w0_reg[CLR_LSB+NFLAG-1:CLR_LSB]) |
                   w0_reg[SET_LSB+NFLAG-1:SET_LSB];
  end

  always_comb begin
    ev_set              = '0;
    ev_set[EV_DONE]     = retire && w0_reg[IRQ_BIT];
    ev_set[EV_ILLEGAL]  = illegal;
    ev_set[EV_FSEQ]     = ce_i && fseq_err_i && state_reg == S_ALIGN &&
                          !w0_reg[AMASK_BIT];
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stat_reg <= '0;
      mask_reg <= MASK_RST;
    end else if (ce_i) begin
      // a new event wins over a simultaneous clear
      if (reg_wr_i && reg_addr_i == REG_STAT)
        stat_reg <= (stat_reg & ~reg_wdata_i[NEVT-1:0]) | ev_set;
      else
        stat_reg <= stat_reg | ev_set;
      if (reg_wr_i && reg_addr_i == REG_MASK)
        mask_reg <= reg_wdata_i[NEVT-1:0];
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  // ****************************************************
  // register port
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      start_reg <= START_RST;
    else if (ce_i && reg_wr_i && reg_addr_i == REG_START)
      start_reg <= reg_wdata_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (ce_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          REG_CTRL:  reg_rdata_o <= {28'h0000000, 1'b0, state_reg};
          REG_START: reg_rdata_o <= start_reg;
          REG_PC:    reg_rdata_o <= pc_reg;
          REG_STAT:  reg_rdata_o <= {29'h0000000, stat_reg};
          REG_MASK:  reg_rdata_o <= {29'h0000000, mask_reg};
          REG_FLAGS: reg_rdata_o <= {28'h0000000, flags_reg};
          default:   reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_bad_fetch;
    illegal;
  endsequence
  sequence s_halted;
    state_reg == S_HALT && !fetch_req_o;
  endsequence

  illegal_halt_a: assert property (s_bad_fetch |=> s_halted)
    else $error("illegal opcode did not halt");
  illegal_irq_a: assert property (illegal |=> stat_reg[EV_ILLEGAL])
    else $error("illegal opcode did not flag");
  branch_pc_a: assert property (retire && state_reg == S_FETCH1 |=>
    pc_reg == $past(fetch_data_i) && state_reg == S_FETCH0)
    else $error("branch target not loaded");
  disc_count_a: assert property (fire |=>
    cnt_reg[$past(sel_reg)] == $past(cnt_reg[sel_reg]) - 12'h001)
    else $error("discard count not decremented");
  lane_pop_a: assert property (q_pop_o[0] && state_reg == S_DISC |->
    lane_reg[0] == 2'd3)
    else $error("pop before word end");
  align_drop_a: assert property (ce_i && state_reg == S_ALIGN &&
    q_valid_i[0] && !tag_hit |-> q_pop_o[0] && !retire)
    else $error("misaligned word not dropped");
  align_hit_a: assert property (retire && state_reg == S_ALIGN |->
    q_tag_i == w0_reg[3:0] ##1 state_reg == S_FETCH0)
    else $error("align ended on wrong tag");
  fseq_mask_a: assert property (ce_i && state_reg == S_ALIGN && fseq_err_i &&
    w0_reg[AMASK_BIT] && !stat_reg[EV_FSEQ] &&
    !(reg_wr_i && reg_addr_i == REG_STAT) |=> !stat_reg[EV_FSEQ])
    else $error("masked field error reported");
  done_irq_a: assert property (retire && w0_reg[IRQ_BIT] |=>
    stat_reg[EV_DONE])
    else $error("completion interrupt missing");
  disc_nowait_a: assert property (ce_i && state_reg == S_DISC &&
    !sel_done && q_valid_i[sel_reg] |=>
    lane_reg[$past(sel_reg)] == $past(lane_reg[sel_reg]) + 2'd1)
    else $error("discard stalled with data present");
endmodule

// ===== testbench/dpsba_partner.sv
`timescale 1ns/1ps
module dpsba_partner (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // holds the luma queue empty
  input  wire logic        stall_i,
  // instruction memory
  input  wire logic        fetch_req_i,
  input  wire logic [31:0] fetch_addr_i,
  output logic             fetch_ack_o,
  output logic [31:0]      fetch_data_o,
  // pixel queues
  input  wire logic [2:0]  q_pop_i,
  output logic [2:0]       q_valid_o,
  output logic [3:0]       q_tag_o
);
  logic [31:0] mem [0:255];
  logic [3:0]  tags [0:63];
  int          pops [3];
  int          wait_cnt;
  int          dly;

  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    foreach (tags[i]) tags[i] = 4'hF;
    fetch_ack_o  = 1'b0;
    fetch_data_o = 32'h0;
    q_valid_o    = 3'h0;
    wait_cnt     = 0;
    dly          = 0;
  end

  // byte-addressed word fetch, answered after 0 to 2 idle cycles
  always @(posedge core_clk_i) begin
    if (srst_i || fetch_ack_o) begin
      fetch_ack_o  <= 1'b0;
      fetch_data_o <= ~fetch_data_o;
      wait_cnt     <= 0;
      dly          <= $urandom_range(0, 2);
    end else if (fetch_req_i && wait_cnt >= dly) begin
      fetch_ack_o  <= 1'b1;
      fetch_data_o <= mem[fetch_addr_i[9:2]];
    end else begin
      fetch_data_o <= ~fetch_data_o;
      wait_cnt     <= wait_cnt + 1;
    end
  end

  // queues present words at random; the tag follows the luma head
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      q_valid_o <= 3'h0;
      pops      <= '{0, 0, 0};
    end else begin
      q_valid_o <= 3'($urandom) & {2'b11, ~stall_i};
      for (int k = 0; k < 3; k++) pops[k] <= pops[k] + int'(q_pop_i[k]);
    end
  end
  assign q_tag_o = tags[6'(pops[0])];
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top
  import dpsba_pkg::*;
;
  logic [AW-1:0]     reg_addr_i  = '0;
  logic [31:0]       reg_wdata_i = '0;
  logic              core_clk_i  = 1'b0;
  logic              srst_i      = 1'b1;
  logic              reg_wr_i    = 1'b0;
  logic              reg_rd_i    = 1'b0;
  logic              fseq_err_i  = 1'b0;
  logic              stall       = 1'b0;
  logic              ce          = 1'b1;
  logic              ce_free     = 1'b0;
  logic [31:0]       reg_rdata_o, fetch_addr_o, fetch_data_i, v;
  logic              fetch_req_o, fetch_ack_i, irq_o;
  logic              line_first_o, line_last_o;
  logic [2:0]        q_valid_i, q_pop_o;
  logic [CODE_W-1:0] q_tag_i;
  int                mismatches = 0;
  int                n_compared = 0;
  int                n_first    = 0;
  int                n_last     = 0;
  int                lane [3]   = '{0, 0, 0};
  int                exp_pops [3] = '{0, 0, 0};

  dpsba_core dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
    .fetch_ack_i(fetch_ack_i), .fetch_data_i(fetch_data_i),
    .q_valid_i(q_valid_i), .q_pop_o(q_pop_o), .q_tag_i(q_tag_i),
    .fseq_err_i(fseq_err_i), .line_first_o(line_first_o),
    .line_last_o(line_last_o), .irq_o(irq_o));

  dpsba_partner u_part (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .stall_i(stall),
    .fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o),
    .fetch_ack_o(fetch_ack_i), .fetch_data_o(fetch_data_i),
    .q_pop_i(q_pop_o), .q_valid_o(q_valid_i), .q_tag_o(q_tag_i));

  always #5 core_clk_i = ~core_clk_i;

  // random enable gaps; a pulse frozen by a low enable counts once
  always @(posedge core_clk_i) begin
    ce <= !ce_free || ($urandom_range(0, 3) != 0);
    if (ce && line_first_o === 1'b1) n_first++;
    if (ce && line_last_o === 1'b1) n_last++;
  end

  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // reserved bits always zero
  function automatic logic [31:0] ins(logic [3:0] op, logic fst, logic lst,
      logic irq, logic [3:0] clr, logic [3:0] set, logic [15:0] lo);
    return {op, fst, lst, 1'b0, irq, clr, set, lo};
  endfunction

  task automatic mdisc(input int k, input int n);
    exp_pops[k] += (lane[k] + n) / 4;
    lane[k] = (lane[k] + n) % 4;
  endtask

  task automatic run(input logic [31:0] start);
    wr(REG_START, start);
    wr(REG_CTRL, 32'h1);
  endtask

  task automatic wait_halt();
    for (int i = 0; i < 400; i++) begin
      rd(REG_CTRL, v);
      if (v[2:0] === 3'h5) break;
    end
    `CHK(v[2:0], 3'h5);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #100us;
    mismatches++;
    summarize();
  end

  // ************************************************
  // tests
  // ************************************************
  initial begin
    int n1, n2, ny, c1, c2, nd, base, p, t;
    logic [31:0] bad [3];
    void'($urandom(32'h8523));
    repeat (10) @(posedge core_clk_i);
    srst_i <= 1'b0;
    n1 = $urandom_range(1, 40);
    n2 = $urandom_range(1, 40);
    ny = $urandom_range(1, 40);
    c1 = $urandom_range(0, 20);
    c2 = $urandom_range(0, 20);
    u_part.mem[16] = ins(OP_DISCARD, 1, 0, 1, 4'h0, 4'h3, 16'(n1));
    u_part.mem[17] = ins(OP_DISCARD, 0, 1, 0, 4'h1, 4'h8, 16'(n2));
    u_part.mem[18] = ins(OP_PLANAR, 0, 0, 0, 4'h0, 4'h0, 16'(ny));
    u_part.mem[19] = {4'h0, 12'(c2), 4'h0, 12'(c1)};
    mdisc(0, n1);
    mdisc(0, n2);
    mdisc(0, ny);
    mdisc(1, c1);
    mdisc(2, c2);
    run(32'h40);
    ce_free <= 1'b1;
    repeat (200) @(posedge core_clk_i);
    ce_free <= 1'b0;
    wait_halt();
    for (int k = 0; k < 3; k++) begin
      `CHK(u_part.pops[k], exp_pops[k]);
    end
    rd(REG_FLAGS, v);
    `CHK(v[3:0], 4'hA);
    rd(REG_STAT, v);
    `CHK(v, 32'h3);
    `CHK(n_first, 1);
    `CHK(n_last, 1);
    rd(4'hF, v);
    `CHK(v, 32'h0);
    wr(REG_MASK, 32'h0);
    `CHK(irq_o, 1'b0);
    wr(REG_MASK, 32'h1);
    `CHK(irq_o, 1'b1);
    wr(REG_STAT, 32'h1);
    `CHK(irq_o, 1'b0);
    wr(REG_STAT, 32'h7);
    $display("test discard done");
    for (int am = 0; am < 2; am++) begin
      p = 40 + am * 4;
      t = 32'h200 + am * 32'h40;
      u_part.mem[p] = ins(OP_BRANCH, 0, 0, 1'(am), 4'h0, 4'h0, 16'h0);
      u_part.mem[p + 1] = 32'(t);
      u_part.mem[t / 4] = ins(OP_ALIGN, 0, 0, 0, 4'h0, 4'h0,
                              {1'(am), 11'h0, 4'h5});
      u_part.mem[t / 4 + 1] = 32'h0;
      base = u_part.pops[0];
      nd = $urandom_range(1, 3);
      for (int j = 0; j < nd; j++) u_part.tags[(base + j) % 64] = 4'h3;
      u_part.tags[(base + nd) % 64] = 4'h5;
      exp_pops[0] += nd;
      lane[0] = 0;
      @(posedge core_clk_i);
      stall <= 1'b1;
      run(32'(p * 4));
      repeat (30) @(posedge core_clk_i);
      fseq_err_i <= 1'b1;
      @(posedge core_clk_i);
      fseq_err_i <= 1'b0;
      stall      <= 1'b0;
      wait_halt();
      `CHK(u_part.pops[0], exp_pops[0]);
      rd(REG_STAT, v);
      `CHK(v, am ? 32'h3 : 32'h6);
      rd(REG_PC, v);
      `CHK(v, t + 12);
      wr(REG_STAT, 32'h7);
    end
    $display("test branch align done");
    bad = '{32'h0, 32'hF000_0000, 32'h8000_0000};
    for (int i = 0; i < 3; i++) begin
      u_part.mem[100 + 2 * i] = bad[i];
      u_part.mem[101 + 2 * i] = 32'h0;
      run(32'((100 + 2 * i) * 4));
      wait_halt();
      rd(REG_STAT, v);
      `CHK(v, 32'h2);
      `CHK(u_part.pops[0], exp_pops[0]);
      wr(REG_STAT, 32'h7);
    end
    $display("test illegal done");
    summarize();
  end
endmodule
